// [shared/cps_map.svh]
// Encodings, reset values and counts of the capture prescaler slice
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH

// Mode select encodings; only 4'h4 to 4'h7 are capture modes
`define CPS_MODE_OFF      4'h0
`define CPS_MODE_FALL     4'h4
`define CPS_MODE_RISE     4'h5
`define CPS_MODE_RISE4    4'h6
`define CPS_MODE_RISE16   4'h7
`define CPS_MODE_CAP_HI   2'h1
`define CPS_MODE_CAP_POS  3:2

// Companion timer clock sources
`define CPS_SRC_INSTR     2'h0
`define CPS_SRC_FOSC      2'h1
`define CPS_SRC_EXT_SYNC  2'h2
`define CPS_SRC_EXT_ASYNC 2'h3

// Instruction clock is the system clock divided by four
`define CPS_DIV_ZERO      2'h0
`define CPS_DIV_LAST      2'h3
`define CPS_DIV_STEP      2'h1

// Last prescaler count before a capture fires
`define CPS_PS_ZERO       4'h0
`define CPS_PS_STEP       4'h1
`define CPS_PS1_LAST      4'h0
`define CPS_PS4_LAST      4'h3
`define CPS_PS16_LAST     4'hf

`define CPS_TMR_RST       16'h0000
`define CPS_CAP_RST       16'h0000

`endif

// [shared/cps_pkg.sv]
// Types shared by the capture prescaler slice
package cps_pkg;

  typedef struct packed {
    logic [3:0] capture_mode_select;
    logic       timer_on;
    logic [1:0] timer_clk_src;
    logic       sleep;
  } cps_ctrl_t;

  typedef struct packed {
    logic capture_irq_enable;
    logic capture_irq_flag_clr;
  } cps_irq_ctrl_t;

  typedef enum logic [2:0] {
    CPS_ST_OFF  = 3'b001,
    CPS_ST_RUN  = 3'b010,
    CPS_ST_HOLD = 3'b100
  } cps_state_t;

endpackage

// [verilog/cps_sync.sv]
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
`default_nettype none

module cps_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = clk_en ? d : meta_r;
    q_nxt    = clk_en ? meta_r : q_r;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire

// [verilog/cps_capture.sv]
// Capture slice: edge prescaler, companion timer and capture flag
//
// Function
// - Capture only with timer or synchronized counter
// - Asynchronous counter mode gives no reliable capture
// - Capture mode change may raise false flag
// - Three prescaler settings (1, 4, 16) from mode select
// - Prescaler cleared when off or not capture
// - Any reset clears prescaler counter
// - Prescaler switch keeps count, may fire falsely
// - Timer must not run from system clock; here it can, and capture then holds
// - Instruction-clocked timer halts in sleep, resumes
// - Synchronized external-clocked timer keeps capture alive in sleep
`timescale 1ns/10ps
`default_nettype none
`include "cps_map.svh"

module cps_capture #(
  parameter int TMR_W = 16
) (
  input  wire logic                   clock,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  input  wire cps_pkg::cps_ctrl_t     ctrl,
  input  wire cps_pkg::cps_irq_ctrl_t irq_ctrl,
  input  wire logic                   capture_input_pin,
  input  wire logic                   timer_ext_clk,
  output var  logic [TMR_W-1:0]       timer_count,
  output var  logic [TMR_W-1:0]       capture_value,
  output var  logic                   capture_irq_flag,
  output var  logic                   capture_irq,
  output var  cps_pkg::cps_state_t    capture_state
);
  import cps_pkg::*;

  // Pins from outside the domain
  logic pin_s;
  logic ext_s;

  cps_sync #(.W(1)) u_pin_sync (
    .clock  (clock),
    .nrst   (nrst),
    .clk_en (clk_en),
    .d      (capture_input_pin),
    .q      (pin_s)
  );

  cps_sync #(.W(1)) u_ext_sync (
    .clock  (clock),
    .nrst   (nrst),
    .clk_en (clk_en),
    .d      (timer_ext_clk),
    .q      (ext_s)
  );

  // Mode decode
  logic       is_cap;
  logic       src_ok;
  logic [3:0] ps_last;
  cps_state_t state_nxt;
  cps_state_t state_r;

  always_comb begin
    is_cap = (ctrl.capture_mode_select[`CPS_MODE_CAP_POS] ==
              `CPS_MODE_CAP_HI);
    // Async counter and raw system clock cannot qualify pin edges
    src_ok = (ctrl.timer_clk_src == `CPS_SRC_INSTR) ||
             (ctrl.timer_clk_src == `CPS_SRC_EXT_SYNC);
    case (ctrl.capture_mode_select)
      `CPS_MODE_RISE4:  ps_last = `CPS_PS4_LAST;
      `CPS_MODE_RISE16: ps_last = `CPS_PS16_LAST;
      default:          ps_last = `CPS_PS1_LAST;
    endcase
    if (!is_cap) begin
      state_nxt = CPS_ST_OFF;
    end else if (src_ok) begin
      state_nxt = CPS_ST_RUN;
    end else begin
      state_nxt = CPS_ST_HOLD;
    end
  end

  // Companion timer
  logic [1:0]       div_r;
  logic [1:0]       div_nxt;
  logic             ext_prev_r;
  logic             ext_prev_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic             tick;

  always_comb begin
    div_nxt      = div_r;
    ext_prev_nxt = ext_s;
    tick         = 1'b0;
    // System clock stops in sleep, so the divider stops with it
    if (!ctrl.sleep) begin
      div_nxt = div_r + `CPS_DIV_STEP;
    end
    case (ctrl.timer_clk_src)
      `CPS_SRC_INSTR: tick = !ctrl.sleep &&
                             (div_r == `CPS_DIV_LAST);
      `CPS_SRC_FOSC:  tick = !ctrl.sleep;
      default:        tick = ext_s && !ext_prev_r;
    endcase
    tmr_nxt = tmr_r;
    if (ctrl.timer_on && tick) begin
      tmr_nxt = tmr_r + {{(TMR_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_r      <= `CPS_DIV_ZERO;
      ext_prev_r <= 1'b0;
      tmr_r      <= `CPS_TMR_RST;
    end else if (clk_en) begin
      div_r      <= div_nxt;
      ext_prev_r <= ext_prev_nxt;
      tmr_r      <= tmr_nxt;
    end
  end

  // Edge qualifier and prescaler
  logic             sel_level;
  logic             sel_prev_r;
  logic             trig;
  logic             fire;
  logic [3:0]       ps_cnt_r;
  logic [3:0]       ps_cnt_nxt;
  logic [TMR_W-1:0] cap_r;
  logic [TMR_W-1:0] cap_nxt;

  always_comb begin
    // Flipping polarity with a steady pin looks like an edge
    sel_level = pin_s ^
                (ctrl.capture_mode_select == `CPS_MODE_FALL);
    trig      = sel_level && !sel_prev_r;
    fire      = 1'b0;
    ps_cnt_nxt = ps_cnt_r;
    cap_nxt    = cap_r;
    case (state_nxt)
      CPS_ST_OFF: begin
        ps_cnt_nxt = `CPS_PS_ZERO;
      end
      CPS_ST_RUN: begin
        if (trig) begin
          // Count left from a larger setting fires early
          if (ps_cnt_r >= ps_last) begin
            fire       = 1'b1;
            ps_cnt_nxt = `CPS_PS_ZERO;
            cap_nxt    = tmr_r;
          end else begin
            ps_cnt_nxt = ps_cnt_r + `CPS_PS_STEP;
          end
        end
      end
      CPS_ST_HOLD: begin
        ps_cnt_nxt = ps_cnt_r;
      end
      default: begin
        ps_cnt_nxt = `CPS_PS_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sel_prev_r <= 1'b0;
      ps_cnt_r   <= `CPS_PS_ZERO;
      cap_r      <= `CPS_CAP_RST;
      state_r    <= CPS_ST_OFF;
    end else if (clk_en) begin
      sel_prev_r <= sel_level;
      ps_cnt_r   <= ps_cnt_nxt;
      cap_r      <= cap_nxt;
      state_r    <= state_nxt;
    end
  end

  // Flag and interrupt request
  logic flag_r;
  logic flag_nxt;
  logic irq_r;
  logic irq_nxt;

  always_comb begin
    // A capture in the clearing cycle is kept
    flag_nxt = fire || (flag_r && !irq_ctrl.capture_irq_flag_clr);
    irq_nxt  = flag_nxt && irq_ctrl.capture_irq_enable;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flag_r <= 1'b0;
      irq_r  <= 1'b0;
    end else if (clk_en) begin
      flag_r <= flag_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign timer_count      = tmr_r;
  assign capture_value    = cap_r;
  assign capture_irq_flag = flag_r;
  assign capture_irq      = irq_r;
  assign capture_state    = state_r;

  // Checks

  sequence fire_step_s;
    clk_en && fire;
  endsequence

  sequence latched_s;
    (cap_r == $past(tmr_r)) && flag_r;
  endsequence

  ps_clear_off_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (clk_en && !is_cap) |=> (ps_cnt_r == `CPS_PS_ZERO))
    else $error("prescaler not cleared outside capture");

  capture_latch_a: assert property (
    @(posedge clock) disable iff (!nrst)
    fire_step_s |=> latched_s)
    else $error("capture did not latch timer or set flag");

  async_no_fire_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (ctrl.timer_clk_src == `CPS_SRC_EXT_ASYNC) |-> !fire)
    else $error("capture fired in async counter mode");

  fosc_no_fire_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (ctrl.timer_clk_src == `CPS_SRC_FOSC) |-> !fire)
    else $error("capture fired with system clock source");

  ps16_count_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (clk_en && fire &&
     ctrl.capture_mode_select == `CPS_MODE_RISE16)
    |-> (ps_cnt_r >= `CPS_PS16_LAST) ##1 (ps_cnt_r == `CPS_PS_ZERO))
    else $error("divide by sixteen fired at wrong count");

  run_edge_fire_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (clk_en && is_cap && ctrl.timer_clk_src == `CPS_SRC_INSTR &&
     trig && ctrl.capture_mode_select != `CPS_MODE_RISE4 &&
     ctrl.capture_mode_select != `CPS_MODE_RISE16) |-> fire)
    else $error("single-edge capture missed in timer mode");

  sleep_halt_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (clk_en && ctrl.sleep &&
     ctrl.timer_clk_src == `CPS_SRC_INSTR)
    |=> (tmr_r == $past(tmr_r)))
    else $error("instruction-clocked timer moved in sleep");

  sleep_ext_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (clk_en && ctrl.sleep && is_cap && trig &&
     ctrl.timer_clk_src == `CPS_SRC_EXT_SYNC && ps_cnt_r >= ps_last)
    |=> flag_r)
    else $error("capture lost in sleep with external clock");

  switch_keep_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (clk_en && is_cap && src_ok && !trig &&
     ctrl.capture_mode_select != $past(ctrl.capture_mode_select))
    |=> (ps_cnt_r == $past(ps_cnt_r)))
    else $error("prescaler cleared on setting switch");

  set_wins_a: assert property (
    @(posedge clock) disable iff (!nrst)
    (clk_en && fire && irq_ctrl.capture_irq_flag_clr) |=> flag_r)
    else $error("capture lost against flag clear");

endmodule

`default_nettype wire

// [bench/cps_pin_model.sv]
// Far-side model: capture pin source and external timer clock
`timescale 1ns/10ps
`default_nettype none

module cps_pin_model (
  input  wire logic clock,
  output var  logic capture_input_pin,
  output var  logic timer_ext_clk
);
  initial begin
    capture_input_pin = 1'b0;
    timer_ext_clk = 1'b0;
  end

  // Levels last 4 cycles so the two-flop sampler never misses one
  task automatic pulse(input int n);
    repeat (n) begin
      capture_input_pin = 1'b1;
      repeat (4) @(negedge clock);
      capture_input_pin = 1'b0;
      repeat (4) @(negedge clock);
    end
  endtask

  // Clock stands low between bursts, like a gated source
  task automatic tick(input int n);
    repeat (n) begin
      timer_ext_clk = 1'b1;
      repeat (3) @(negedge clock);
      timer_ext_clk = 1'b0;
      repeat (3) @(negedge clock);
    end
  endtask
endmodule

`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the capture prescaler slice
`timescale 1ns/10ps
`default_nettype none
`include "cps_map.svh"

module tb;
  import cps_pkg::*;
  logic          clock;
  logic          nrst;
  logic          clk_en;
  cps_ctrl_t     ctrl;
  cps_irq_ctrl_t irq_ctrl;
  wire logic     pin;
  wire logic     ext_clk;
  logic [15:0]   tmr;
  logic [15:0]   cap;
  logic          flag;
  logic          irq;
  cps_state_t    state;
  logic [15:0]   exp_tmr;
  logic [15:0]   d;
  int            mismatches;
  int            check_count;
  int            n [4] = '{1, 1, 4, 16};

  cps_capture #(.TMR_W(16)) i_dut (
    .clock(clock), .nrst(nrst), .clk_en(clk_en), .ctrl(ctrl),
    .irq_ctrl(irq_ctrl), .capture_input_pin(pin),
    .timer_ext_clk(ext_clk), .timer_count(tmr), .capture_value(cap),
    .capture_irq_flag(flag), .capture_irq(irq), .capture_state(state)
  );

  cps_pin_model i_pin (
    .clock(clock), .capture_input_pin(pin), .timer_ext_clk(ext_clk)
  );

  always #2 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    check_count++;
    if (seen !== expd) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask

  // A mode change that flips the edge polarity may leave a false flag behind
  task automatic set_mode(input logic [3:0] m);
    ctrl.capture_mode_select = m;
    cyc(1);
    irq_ctrl.capture_irq_flag_clr = 1'b1;
    cyc(1);
    irq_ctrl.capture_irq_flag_clr = 1'b0;
    cyc(1);
  endtask

  task automatic ev(input int k);
    i_pin.pulse(k);
  endtask

  task automatic tk(input int k);
    i_pin.tick(k);
    exp_tmr = exp_tmr + 16'(k);
  endtask

  task automatic reset_check();
    check(tmr, `CPS_TMR_RST);
    check(cap, `CPS_CAP_RST);
    check({15'h0000, flag}, 16'h0000);
    check({13'h0000, state}, {13'h0000, CPS_ST_OFF});
  endtask

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    ctrl = '0;
    ctrl.timer_on = 1'b1;
    ctrl.timer_clk_src = `CPS_SRC_EXT_SYNC;
    irq_ctrl = '0;
    exp_tmr = 16'h0000;
    cyc(4);
    reset_check();
    nrst = 1'b1;
    cyc(2);
    for (int i = 0; i < 4; i++) begin
      irq_ctrl.capture_irq_enable = i[0];
      set_mode(`CPS_MODE_OFF);
      set_mode(`CPS_MODE_FALL + 4'(i));
      tk(3);
      ev(n[i] - 1);
      check({15'h0000, flag}, 16'h0000);
      ev(1);
      check({15'h0000, flag}, 16'h0001);
      check(cap, exp_tmr);
      check({15'h0000, irq}, {15'h0000, i[0]});
      check({13'h0000, state}, {13'h0000, CPS_ST_RUN});
    end
    irq_ctrl.capture_irq_enable = 1'b1;
    // Direct prescaler switch keeps the count, so it fires early
    set_mode(`CPS_MODE_OFF);
    set_mode(`CPS_MODE_RISE16);
    ev(5);
    set_mode(`CPS_MODE_RISE4);
    ev(1);
    check({15'h0000, flag}, 16'h0001);
    set_mode(`CPS_MODE_RISE16);
    ev(5);
    set_mode(`CPS_MODE_OFF);
    set_mode(`CPS_MODE_RISE4);
    ev(3);
    check({15'h0000, flag}, 16'h0000);
    ev(1);
    check({15'h0000, flag}, 16'h0001);
    ctrl.sleep = 1'b1;
    set_mode(`CPS_MODE_RISE);
    tk(2);
    ev(1);
    check({15'h0000, flag}, 16'h0001);
    check(cap, exp_tmr);
    ctrl.timer_clk_src = `CPS_SRC_INSTR;
    cyc(20);
    check(tmr, exp_tmr);
    ctrl.sleep = 1'b0;
    cyc(40);
    ctrl.timer_on = 1'b0;
    cyc(2);
    // Forty awake clocks at a quarter rate give ten increments
    d = tmr - exp_tmr;
    check(d, 16'h000a);
    exp_tmr = exp_tmr + 16'h000a;
    // Clock enable low must freeze the running timer
    clk_en = 1'b0;
    ctrl.timer_on = 1'b1;
    cyc(8);
    check(tmr, exp_tmr);
    clk_en = 1'b1;
    ctrl.timer_clk_src = `CPS_SRC_EXT_SYNC;
    set_mode(`CPS_MODE_RISE4);
    ev(2);
    nrst = 1'b0;
    cyc(2);
    reset_check();
    nrst = 1'b1;
    exp_tmr = 16'h0000;
    set_mode(`CPS_MODE_RISE4);
    ev(3);
    check({15'h0000, flag}, 16'h0000);
    ev(1);
    check({15'h0000, flag}, 16'h0001);
    check(cap, exp_tmr);
    for (int s = 1; s < 4; s += 2) begin
      ctrl.timer_clk_src = 2'(s);
      set_mode(`CPS_MODE_OFF);
      set_mode(`CPS_MODE_RISE);
      ev(1);
      check({15'h0000, flag}, 16'h0000);
      check({13'h0000, state}, {13'h0000, CPS_ST_HOLD});
    end
    stop_test();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    cyc(20000);
    mismatches++;
    stop_test();
  end
endmodule

`default_nettype wire
